// ---- aoir_defines.svh ----
// Purpose: offsets, field positions, reset values and timing figures of the
//          offset and infrared recovery parameter block
// Assumes: included by bare name wherever a figure is needed
// Notes:   definitions only
`ifndef AOIR_DEFINES_SVH
`define AOIR_DEFINES_SVH

// parameter offsets on the register port
`define AOIR_OFS_MEAS_OFFSET   8'h1a
`define AOIR_OFS_LED_RECOVERY_RESERVED_SLOT  8'h1c
`define AOIR_OFS_IR_REC_PARAM  8'h1d
`define AOIR_OFS_IR_GAIN       8'h1e
`define AOIR_OFS_STATUS        8'h20
`define AOIR_OFS_RESULT_LO     8'h22
`define AOIR_OFS_RESULT_HI     8'h23

// reset values
`define AOIR_RST_MEAS_OFFSET   8'h80
`define AOIR_RST_LED_RECOVERY_RESERVED_SLOT  8'h00
`define AOIR_RST_IR_REC_SEL    3'h7
`define AOIR_RST_IR_REC_PARAM  8'h70
`define AOIR_RST_IR_GAIN       3'h0

// field positions
`define AOIR_REC_SEL_MSB       6
`define AOIR_REC_SEL_LSB       4
`define AOIR_GAIN_MSB          2
`define AOIR_GAIN_LSB          0
`define AOIR_STAT_BUSY         0
`define AOIR_STAT_RECOVER      1
`define AOIR_STAT_OVERRANGE    2
`define AOIR_STAT_VALID        3

// result codes
`define AOIR_OVERRANGE_CODE    16'hffff
`define AOIR_MAX_LEGAL_CODE    16'hfffe

// first sequencer revision that carries the infrared recovery parameter
`define AOIR_REV_IR_MIN        3

// timing: one undivided ADC clock and the reference clock period
`define AOIR_ADC_CLK_NS        50
`define AOIR_REF_CLK_NS        50
`define AOIR_ADC_CLK_CYC       ((`AOIR_ADC_CLK_NS + `AOIR_REF_CLK_NS - 1) / `AOIR_REF_CLK_NS)

`endif

// ---- aoir_pkg.sv ----
// Purpose: types and shared arithmetic of the offset and recovery block
// Assumes: aoir_defines.svh supplies every figure
// Notes:   each function is called from one process only
package aoir_pkg;
  `include "aoir_defines.svh"

  typedef logic [7:0]  aoir_byte_t;   // one parameter byte
  typedef logic [15:0] aoir_word_t;   // one measurement result
  typedef logic [2:0]  aoir_code3_t;  // select or exponent code

  // recovery base in ADC clocks: 1, 7, 15 ... 511
  function automatic logic [8:0] aoir_rec_base(input aoir_code3_t sel);
    logic [9:0] p;
    p = 10'h000;
    if (sel == 3'h0) begin
      aoir_rec_base = 9'h001;
    end else begin
      // widened before the add so code 7 reaches 2^9 instead of wrapping
      p = 10'h001 << ({1'b0, sel} + 4'h2);
      p = p - 10'h001;
      aoir_rec_base = p[8:0];
    end
  endfunction

  // compressed byte: high nibble exponent, low nibble mantissa with hidden one
  function automatic aoir_word_t aoir_expand(input aoir_byte_t c);
    logic [31:0] m;
    m = {27'h000_0000, 1'b1, c[3:0]};
    if (c[7:4] >= 4'h4) begin
      m = m << (c[7:4] - 4'h4);
    end else begin
      m = m >> (4'h4 - c[7:4]);
    end
    aoir_expand = m[15:0];
  endfunction
endpackage

// ---- aoir_seq_if.sv ----
// Purpose: carrier between the parameter file and the recovery sequencer
// Assumes: one clock domain
// Notes:   all signals synchronous to ref_clk
`timescale 1ns/100ps
interface aoir_seq_if;
  logic        start;       // one-cycle start of an infrared conversion
  logic [2:0]  rec_sel;     // effective recovery select
  logic [2:0]  gain;        // effective gain exponent
  logic        meas_done;   // converter delivered the sample
  logic        busy;        // sequence in progress
  logic        recovering;  // recovery wait in progress
  logic        adc_tick;    // one divided ADC clock during integration

  modport regs (output start, rec_sel, gain, meas_done, input busy, recovering, adc_tick);
  modport seq  (input start, rec_sel, gain, meas_done, output busy, recovering, adc_tick);
endinterface

// ---- aoir_seq.sv ----
// Purpose: recovery wait and divided ADC clock for infrared conversions
// Assumes: start is a one-cycle pulse; meas_done ends integration
// Notes:   prescaler of 2^gain ADC clocks scales both recovery and integration
`timescale 1ns/100ps
`include "aoir_defines.svh"
module aoir_seq
  import aoir_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  aoir_seq_if.seq   sif
);
  import aoir_pkg::*;

  typedef enum logic [1:0] {AOIR_IDLE, AOIR_RECOVER, AOIR_INTEG} aoir_st_t;

  typedef struct packed {
    aoir_st_t    st;     // sequence state
    logic [7:0]  presc;  // reference cycles left in this ADC clock
    logic [8:0]  cnt;    // ADC clocks of recovery left
    logic [7:0]  limit;  // prescaler reload, latched at start
  } aoir_seq_s_t;

  aoir_seq_s_t s_q;  // registered state
  aoir_seq_s_t s_d;  // next state
  logic        tick; // end of one divided ADC clock

  assign tick           = (s_q.presc == 8'h00);
  assign sif.busy       = (s_q.st != AOIR_IDLE);
  assign sif.recovering = (s_q.st == AOIR_RECOVER);
  assign sif.adc_tick   = (s_q.st == AOIR_INTEG) && tick;

  // next-state logic
  always_comb begin
    logic [7:0] lim;
    lim = 8'h00;
    s_d = s_q;
    // divided ADC clock runs while the sequence is active
    if (s_q.st != AOIR_IDLE) begin
      s_d.presc = tick ? s_q.limit : s_q.presc - 8'h01;
    end
    unique case (s_q.st)
      AOIR_IDLE: begin
        // a start while busy is ignored by construction
        if (sif.start) begin
          lim       = 8'((`AOIR_ADC_CLK_CYC << sif.gain) - 1);
          s_d.limit = lim;
          s_d.presc = lim;
          s_d.cnt   = aoir_rec_base(sif.rec_sel) - 9'h001;
          s_d.st    = AOIR_RECOVER;
        end
      end
      AOIR_RECOVER: begin
        // base ADC clocks, each 2^gain reference clocks long
        if (tick) begin
          if (s_q.cnt == 9'h000) begin
            s_d.st = AOIR_INTEG;
          end else begin
            s_d.cnt = s_q.cnt - 9'h001;
          end
        end
      end
      AOIR_INTEG: begin
        // converter integrates on adc_tick until it reports
        if (sif.meas_done) begin
          s_d.st = AOIR_IDLE;
        end
      end
      default: begin
        // unused state code: fall back to idle
        s_d.st = AOIR_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '{st: AOIR_IDLE, presc: 8'h00, cnt: 9'h000, limit: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ---- aoir_top.sv ----
// Purpose: offset and infrared recovery parameters with result offsetting
// Assumes: register port strobes are one cycle, never both at once
// Notes:   read data stand in the cycle after the read strobe only
`timescale 1ns/100ps
`include "aoir_defines.svh"

module aoir_top
  import aoir_pkg::*;
#(
  parameter int unsigned SEQ_REVISION = 3  // sequencer revision number
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire aoir_pkg::aoir_byte_t reg_addr,
  input  wire aoir_pkg::aoir_byte_t reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output aoir_pkg::aoir_byte_t   reg_rdata,
  input  wire logic              ir_start,
  input  wire logic              conv_valid,
  input  wire aoir_pkg::aoir_word_t conv_raw,
  input  wire aoir_pkg::aoir_word_t conv_ref,
  input  wire logic              conv_overrange,
  output logic                   adc_tick,
  output logic                   ir_busy,
  output logic                   ir_recovering,
  output aoir_pkg::aoir_word_t   result_data,
  output logic                   result_valid
);
  import aoir_pkg::*;

  // the recovery and gain parameters exist only on later sequencers
  localparam logic HAS_IR_REC = (SEQ_REVISION >= `AOIR_REV_IR_MIN);

  typedef struct packed {
    aoir_byte_t  offset;    // compressed measurement offset
    aoir_byte_t  led_recovery_reserved;   // reserved slot, stored without effect
    aoir_code3_t rec_sel;   // infrared recovery select
    aoir_code3_t gain;      // infrared gain exponent
    aoir_byte_t  rdata;     // read data, valid one cycle
    aoir_word_t  result;    // last reported result
    logic        valid;     // result strobe
    logic        ovr;       // last result was overrange
    logic        have;      // a result has been reported
  } aoir_regs_t;

  aoir_regs_t  r_q;        // registered state
  aoir_regs_t  r_d;        // next state
  aoir_word_t  off16;      // expanded offset
  aoir_word_t  res_calc;   // offset and clamped result
  aoir_byte_t  rd_mux;     // read multiplexer
  logic [17:0] sum;        // signed relative sum, two guard bits

  aoir_seq_if sif ();

  // sequencer sees the effective parameters
  assign sif.start     = ir_start;
  assign sif.rec_sel   = HAS_IR_REC ? r_q.rec_sel : 3'h0;
  assign sif.gain      = HAS_IR_REC ? r_q.gain : 3'h0;
  assign sif.meas_done = conv_valid;

  aoir_seq u_seq (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .sif     (sif)
  );

  assign adc_tick      = sif.adc_tick;
  assign ir_busy       = sif.busy;
  assign ir_recovering = sif.recovering;
  assign reg_rdata     = r_q.rdata;
  assign result_data   = r_q.result;
  assign result_valid  = r_q.valid;

  // result arithmetic: relative sample plus expanded offset
  always_comb begin
    off16 = aoir_expand(r_q.offset);
    // relative measurement may go negative before the offset lifts it
    sum = {2'b00, conv_raw} - {2'b00, conv_ref} + {2'b00, off16};
    if (conv_overrange) begin
      res_calc = `AOIR_OVERRANGE_CODE;
    end else if (sum[17]) begin
      // still negative: floor at zero rather than wrap toward 0xFFFF
      res_calc = 16'h0000;
    end else if (sum[16:0] >= {1'b0, `AOIR_OVERRANGE_CODE}) begin
      // clamp below the marker so it is never forged by arithmetic
      res_calc = `AOIR_MAX_LEGAL_CODE;
    end else begin
      res_calc = sum[15:0];
    end
  end

  // read multiplexer; unmapped offsets read zero
  always_comb begin
    unique case (reg_addr)
      `AOIR_OFS_MEAS_OFFSET:  rd_mux = r_q.offset;
      `AOIR_OFS_LED_RECOVERY_RESERVED_SLOT: rd_mux = r_q.led_recovery_reserved;
      // reserved bits 7 and 3:0 read zero
      `AOIR_OFS_IR_REC_PARAM: rd_mux = HAS_IR_REC ? {1'b0, r_q.rec_sel, 4'h0} : 8'h00;
      `AOIR_OFS_IR_GAIN:      rd_mux = HAS_IR_REC ? {5'h00, r_q.gain} : 8'h00;
      `AOIR_OFS_STATUS: begin
        rd_mux = 8'h00;
        rd_mux[`AOIR_STAT_BUSY]      = sif.busy;
        rd_mux[`AOIR_STAT_RECOVER]   = sif.recovering;
        rd_mux[`AOIR_STAT_OVERRANGE] = r_q.ovr;
        rd_mux[`AOIR_STAT_VALID]     = r_q.have;
      end
      `AOIR_OFS_RESULT_LO:    rd_mux = r_q.result[7:0];
      `AOIR_OFS_RESULT_HI:    rd_mux = r_q.result[15:8];
      default:                rd_mux = 8'h00;
    endcase
  end

  // register file and result capture
  always_comb begin
    r_d       = r_q;
    r_d.valid = 1'b0;
    // read data live for one cycle only
    r_d.rdata = reg_rd ? rd_mux : 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        `AOIR_OFS_MEAS_OFFSET:  r_d.offset = reg_wdata;
        `AOIR_OFS_LED_RECOVERY_RESERVED_SLOT: r_d.led_recovery_reserved = reg_wdata;
        `AOIR_OFS_IR_REC_PARAM: begin
          // reserved bits are dropped; host keeps them zero
          if (HAS_IR_REC) begin
            r_d.rec_sel = reg_wdata[`AOIR_REC_SEL_MSB:`AOIR_REC_SEL_LSB];
          end
        end
        `AOIR_OFS_IR_GAIN: begin
          if (HAS_IR_REC) begin
            r_d.gain = reg_wdata[`AOIR_GAIN_MSB:`AOIR_GAIN_LSB];
          end
        end
        default: begin
          // unmapped or read-only offsets: write ignored
        end
      endcase
    end
    // every converter sample is reported; non-overrange ones with the offset applied
    if (conv_valid) begin
      r_d.result = res_calc;
      r_d.valid  = 1'b1;
      r_d.ovr    = conv_overrange;
      r_d.have   = 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_q <= '{offset:  `AOIR_RST_MEAS_OFFSET,
               led_recovery_reserved: `AOIR_RST_LED_RECOVERY_RESERVED_SLOT,
               rec_sel: `AOIR_RST_IR_REC_SEL,
               gain:    `AOIR_RST_IR_GAIN,
               rdata:   8'h00,
               result:  16'h0000,
               valid:   1'b0,
               ovr:     1'b0,
               have:    1'b0};
    end else begin
      r_q <= r_d;
    end
  end
endmodule

// ---- aoir_chk_properties.sv ----
// Purpose: port checker of the offset and recovery block
// Assumes: select and gain mirrored from register writes
// Notes:   bound into aoir_top below
`timescale 1ns/100ps
module aoir_chk
  import aoir_pkg::*;
#(
  parameter int unsigned SEQ_REVISION = 3  // sequencer revision
)
(
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire aoir_pkg::aoir_byte_t  reg_addr,
  input wire aoir_pkg::aoir_byte_t  reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  conv_valid,
  input wire logic                  conv_overrange,
  input wire logic                  adc_tick,
  input wire logic                  ir_start,
  input wire logic                  ir_busy,
  input wire logic                  ir_recovering,
  input wire aoir_pkg::aoir_word_t  result_data,
  input wire logic                  result_valid
);
  logic [2:0]  sel_q;   // mirrored select
  logic [2:0]  gain_q;  // mirrored gain
  logic [16:0] rec_q;   // recovery cycles so far
  logic [16:0] rec_exp; // expected recovery length
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // mirror writes; old revisions ignore them
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sel_q <= (SEQ_REVISION >= 3) ? 3'h7 : 3'h0;
      gain_q <= 3'h0;
    end else if (reg_wr && SEQ_REVISION >= 3) begin
      if (reg_addr == 8'h1d) sel_q <= reg_wdata[6:4];
      if (reg_addr == 8'h1e) gain_q <= reg_wdata[2:0];
    end
  end
  // count recovery cycles
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !ir_recovering) rec_q <= 17'h0_0000;
    else rec_q <= rec_q + 17'h0_0001;
  end
  // base clocks scaled by two to the gain
  always_comb begin
    rec_exp = (sel_q == 3'h0) ? 17'h0_0001 : (17'h0_0001 << (sel_q + 4'h2)) - 17'h0_0001;
    rec_exp = rec_exp << gain_q;
  end
  chk_valid_follows: assert property (conv_valid |=> result_valid)
    else $error("no result after sample");
  chk_valid_single: assert property (!conv_valid |=> !result_valid)
    else $error("result without sample");
  chk_over_code: assert property (conv_valid && conv_overrange |=> result_data == 16'hffff)
    else $error("overrange not marked");
  chk_never_marker: assert property (conv_valid && !conv_overrange |=> result_data != 16'hffff)
    else $error("result equals overrange marker");
  chk_start_recover: assert property (ir_start && !ir_busy |=> ir_busy && ir_recovering)
    else $error("recovery did not start");
  chk_rec_length: assert property ($fell(ir_recovering) |-> rec_q == rec_exp)
    else $error("recovery length wrong");
  chk_tick_quiet: assert property (ir_recovering || !ir_busy |-> !adc_tick)
    else $error("tick outside integration");
  chk_busy_end: assert property (ir_busy && !ir_recovering && conv_valid |=> !ir_busy)
    else $error("busy held after sample");
  cover property (conv_valid && conv_overrange);
  cover property ($fell(ir_recovering));
  cover property (adc_tick);
endmodule

bind aoir_top aoir_chk #(.SEQ_REVISION(SEQ_REVISION)) i_aoir_chk (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .conv_valid, .conv_overrange, .adc_tick, .ir_start, .ir_busy, .ir_recovering, .result_data,
  .result_valid);

// ---- aoir_conv_model.sv ----
// Purpose: converter model on the far side of the block
// Assumes: bench pulses req for a plain sample
// Notes:   infrared run ends on the second tick
`timescale 1ns/100ps
module aoir_conv_model
  import aoir_pkg::*;
(
  input wire logic                   ref_clk,
  input wire logic                   adc_tick,
  input wire logic                   ir_busy,
  input wire logic                   ir_recovering,
  input wire logic                   req,
  input wire aoir_pkg::aoir_word_t   raw_in,
  input wire aoir_pkg::aoir_word_t   ref_in,
  input wire logic                   ovr_in,
  output logic                       conv_valid = 1'b0,
  output aoir_pkg::aoir_word_t       conv_raw = 16'h5555,
  output aoir_pkg::aoir_word_t       conv_ref = 16'haaaa,
  output logic                       conv_overrange = 1'b0
);
  logic [1:0] ticks_q = 2'h0;  // ticks in this integration
  // stale data toggles so it never looks like a sample
  always @(posedge ref_clk) begin
    conv_valid <= 1'b0;
    conv_overrange <= 1'b0;
    conv_raw <= ~conv_raw;
    conv_ref <= ~conv_ref;
    if (!ir_busy || ir_recovering) ticks_q <= 2'h0;
    else if (adc_tick && ticks_q != 2'h3) ticks_q <= ticks_q + 2'h1;
    // integration ends only after the recovery wait
    if (req || (adc_tick && ticks_q == 2'h1 && ir_busy && !ir_recovering)) begin
      conv_valid <= 1'b1;
      conv_raw <= raw_in;
      conv_ref <= ref_in;
      conv_overrange <= ovr_in;
    end
  end
endmodule

// ---- adc_offset_ir_recovery_params_test.sv ----
// Purpose: register and sequence test of the offset and recovery block
// Assumes: converter model supplies samples
// Notes:   register reset values from the register table
`timescale 1ns/100ps
module adc_offset_ir_recovery_params_test;
  import aoir_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  aoir_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, ir_start = 1'b0, req = 1'b0, ovr = 1'b0;
  aoir_word_t raw = 16'h1000, refv = 16'h1000, conv_raw, conv_ref, result_data;
  logic       conv_valid, conv_overrange, adc_tick, ir_busy, ir_recovering, result_valid;
  int         mismatches = 0, n_tests = 0, n, m;
  always #25 ref_clk = ~ref_clk;
  aoir_top i_aoir_top (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ir_start,
    .conv_valid, .conv_raw, .conv_ref, .conv_overrange, .adc_tick, .ir_busy, .ir_recovering, .result_data,
    .result_valid);
  aoir_conv_model i_aoir_conv_model (.ref_clk, .adc_tick, .ir_busy, .ir_recovering, .req, .raw_in(raw),
    .ref_in(refv), .ovr_in(ovr), .conv_valid, .conv_raw, .conv_ref, .conv_overrange);
  // verdict
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input aoir_byte_t a, input aoir_byte_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input aoir_byte_t a, input aoir_byte_t e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // bounded wait for a result
  task automatic wres(input aoir_word_t e);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (result_valid !== 1'b1 && n < 3000);
    if (result_valid !== 1'b1) begin
      mismatches++;
      results();
    end
    chk(result_data, e);
  endtask
  task automatic cv(input aoir_word_t r, input aoir_word_t f, input logic o, input aoir_word_t e);
    @(posedge ref_clk);
    raw <= r;
    refv <= f;
    ovr <= o;
    req <= 1'b1;
    @(posedge ref_clk);
    req <= 1'b0;
    wres(e);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h1a, 8'h80);
    rd(8'h1c, 8'h00);
    rd(8'h1d, 8'h70);
    rd(8'h1b, 8'h00);
    wr(8'h1c, 8'ha5);
    rd(8'h1c, 8'ha5);
    $display("test registers done");
    // codes 0x60, 0x70, 0x80 give 64, 128, 256
    for (int i = 0; i < 3; i++) begin
      wr(8'h1a, 8'h60 + 8'(i * 16));
      cv(16'h1000, 16'h1000, 1'b0, 16'h0040 << i);
    end
    rd(8'h22, 8'h00);
    rd(8'h23, 8'h01);
    // a relative result below zero must not wrap toward the marker
    cv(16'h0000, 16'h0200, 1'b0, 16'h0000);
    cv(16'hffff, 16'h0000, 1'b0, 16'hfffe);
    cv(16'h0010, 16'h0000, 1'b1, 16'hffff);
    // status: idle, last sample overranged, a result exists
    rd(8'h20, 8'h0c);
    $display("test offset done");
    raw <= 16'h1000;
    refv <= 16'h1000;
    ovr <= 1'b0;
    // select is the complement of gain, so every code is used
    for (int g = 0; g < 8; g++) begin
      wr(8'h1e, 8'(g));
      wr(8'h1d, {1'b0, ~3'(g), 4'h0});
      rd(8'h1d, {1'b0, ~3'(g), 4'h0});
      @(posedge ref_clk);
      ir_start <= 1'b1;
      @(posedge ref_clk);
      ir_start <= 1'b0;
      #1;
      chk({ir_busy, ir_recovering}, 16'h0003);
      m = 0;
      // longest recovery here is 511 cycles; the bound only catches a hang
      while (ir_recovering === 1'b1 && m < 2000) begin
        @(posedge ref_clk);
        #1;
        m++;
      end
      if (m >= 2000) begin
        mismatches++;
        results();
      end
      chk(16'(m), ((g == 7) ? 16'h0001 : (16'h0001 << (9 - g)) - 16'h0001) << g);
      wres(16'h0100);
    end
    // status after the last run: idle, no overrange, a result exists
    rd(8'h20, 8'h08);
    $display("test recovery done");
    results();
  end
endmodule
